// ===== core/eecc_pkg.sv
// constants and types shared by the eeprom command controller
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package eecc_pkg;
  // register byte addresses
  localparam logic [7:0] EECC_OFS_CMD = 8'hb0;
  localparam logic [7:0] EECC_OFS_DATA = 8'hb4;
  // command register fields
  localparam int EECC_BIT_BUSY = 31;
  localparam int EECC_POS_OP = 28;
  localparam int EECC_BIT_TMO = 9;
  localparam int EECC_BIT_LOADED = 8;
  localparam logic [7:0] EECC_ADDR_RST = 8'h00;
  localparam logic [7:0] EECC_DATA_RST = 8'h00;
  // signature byte at location 0 that marks a valid memory
  localparam logic [7:0] EECC_SIGNATURE = 8'ha5;
  // timing
  localparam int EECC_CLK_MHZ = 200;
  localparam int EECC_TMO_MS = 30;
  localparam int EECC_TMO_CYC = EECC_TMO_MS * EECC_CLK_MHZ * 1000;
  localparam int EECC_SK_HALF_NS = 100;
  localparam int EECC_SK_HALF_CYC = (EECC_SK_HALF_NS * EECC_CLK_MHZ + 999) / 1000;
  // cycles before the synchronised line reflects the level after chip select rose
  localparam int EECC_SYNC_LAT = 4;
  // frame lengths in serial bits
  localparam int EECC_FRAME_HDR = 11;
  localparam int EECC_FRAME_DATA = 19;
  // commands in the op field
  typedef enum logic [2:0] {
    EECC_OP_READ = 3'h0,
    EECC_OP_EWDS = 3'h1,
    EECC_OP_ERASE_WRITE_ENABLE_CMD = 3'h2,
    EECC_OP_WRITE = 3'h3,
    EECC_OP_WRITE_ALL_CMD = 3'h4,
    EECC_OP_ERASE = 3'h5,
    EECC_OP_ERASE_ALL_CMD = 3'h6,
    EECC_OP_RELOAD = 3'h7
  } eecc_op_t;
  typedef enum logic [2:0] {
    EECC_ST_IDLE,
    EECC_ST_SHIFT,
    EECC_ST_GAP,
    EECC_ST_WAIT,
    EECC_ST_DONE
  } eecc_state_t;
endpackage

// ===== core/eecc_sync.sv
// three-stage input synchroniser that passes a change once the last two stages agree
`timescale 1ns/1ps
`default_nettype none
module eecc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_out;
  // ----------------------------------------------------------------------------
  // shift chain
  // ----------------------------------------------------------------------------
  always_comb
  begin
    next_stage = {stage[1:0], async_in};
    next_out = (stage[1] == stage[2]) ? stage[2] : sync_out; // first stage feeds stage 1 only
  end
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage <= {3{RESET_VAL}};
      sync_out <= RESET_VAL;
    end
    else if (ce)
    begin
      stage <= next_stage;
      sync_out <= next_out;
    end
  end
endmodule
`default_nettype wire

// ===== core/eecc_top.sv
// eeprom command controller with apb registers and serial memory port
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module eecc_top
  import eecc_pkg::*;
#(
  parameter int TMO_CYC = eecc_pkg::EECC_TMO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_cs,
  output logic mem_sk,
  output logic mem_di_out,
  input wire logic serial_mem_data_line_in,
  output logic serial_mem_data_line_out,
  output logic serial_mem_data_line_oe
);
  import eecc_pkg::*;

  // refuse a time-out that the 23-bit counter or the ready blanking cannot serve
  if (TMO_CYC <= EECC_SYNC_LAT || TMO_CYC > 8388607)
  begin
    $error("TMO_CYC out of range");
  end

  logic line_s;
  eecc_state_t state, next_state;
  eecc_op_t op, next_op;
  logic busy, next_busy, tmo, next_tmo, loaded, next_loaded, boot, next_boot;
  logic [7:0] addr, next_addr, data, next_data, rsh, next_rsh;
  logic [18:0] tsh, next_tsh;
  logic [4:0] bitn, next_bitn, nbits;
  logic [7:0] div, next_div;
  logic [22:0] tcnt, next_tcnt;
  logic sk, next_sk, cs, next_cs;
  logic [31:0] next_prdata;
  logic next_slverr, tick, setup, wr_cmd, wr_data, start;
  logic [1:0] opc;
  logic [7:0] fa;
  eecc_op_t cmd_op;

  // ----------------------------------------------------------------------------
  // input synchroniser for the data line
  // ----------------------------------------------------------------------------
  eecc_sync #(.RESET_VAL(1'b0)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .async_in(serial_mem_data_line_in),
    .sync_out(line_s)
  );

  // ----------------------------------------------------------------------------
  // apb decode, zero wait states
  // ----------------------------------------------------------------------------
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign wr_cmd = setup && pwrite && paddr == EECC_OFS_CMD;
  assign wr_data = setup && pwrite && paddr == EECC_OFS_DATA && !busy;
  assign start = wr_cmd && !busy && pwdata[EECC_BIT_BUSY];
  assign tick = div == 8'(EECC_SK_HALF_CYC - 1);
  // command taken at start: the power-up reload wins over a host command
  assign cmd_op = boot ? EECC_OP_RELOAD : eecc_op_t'(pwdata[EECC_POS_OP +: 3]);

  // opcode and address bits of the serial frame
  always_comb
  begin
    opc = 2'b00;
    fa = (wr_cmd && !busy) ? pwdata[7:0] : addr;
    case (cmd_op)
      EECC_OP_READ, EECC_OP_RELOAD: opc = 2'b10;
      EECC_OP_WRITE: opc = 2'b01;
      EECC_OP_ERASE: opc = 2'b11;
      EECC_OP_ERASE_WRITE_ENABLE_CMD: fa = 8'hc0;
      EECC_OP_EWDS: fa = 8'h00;
      EECC_OP_WRITE_ALL_CMD: fa = 8'h40;
      EECC_OP_ERASE_ALL_CMD: fa = 8'h80;
      default: opc = 2'b10;
    endcase
    if (cmd_op == EECC_OP_RELOAD) fa = 8'h00;
  end

  assign nbits = (op == EECC_OP_READ || op == EECC_OP_RELOAD || op == EECC_OP_WRITE ||
                  op == EECC_OP_WRITE_ALL_CMD) ? 5'(EECC_FRAME_DATA) : 5'(EECC_FRAME_HDR);

  // ----------------------------------------------------------------------------
  // command sequencer next state
  // ----------------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_op = op;
    next_busy = busy;
    next_tmo = tmo;
    next_loaded = loaded;
    next_boot = boot;
    next_addr = addr;
    next_data = data;
    next_rsh = rsh;
    next_tsh = tsh;
    next_bitn = bitn;
    next_div = (state == EECC_ST_IDLE || tick) ? 8'h00 : div + 8'h01;
    next_tcnt = tcnt;
    next_sk = sk;
    next_cs = cs;
    if (wr_cmd && !busy) next_addr = pwdata[7:0];
    if (wr_data) next_data = pwdata[7:0];
    case (state)
      EECC_ST_IDLE:
      begin
        if (start || boot)
        begin
          next_op = cmd_op;
          next_boot = 1'b0;
          next_busy = 1'b1;
          next_tmo = 1'b0;
          next_cs = 1'b1;
          next_bitn = 5'h00;
          next_tsh = {1'b1, opc, fa, next_data};
          next_state = EECC_ST_SHIFT;
        end
      end
      EECC_ST_SHIFT:
      begin
        if (tick && !sk)
        begin
          next_sk = 1'b1;
          if (bitn >= 5'(EECC_FRAME_HDR)) next_rsh = {rsh[6:0], line_s};
        end
        else if (tick)
        begin
          next_sk = 1'b0;
          next_tsh = {tsh[17:0], 1'b0};
          next_bitn = bitn + 5'h01;
          if (bitn + 5'h01 == nbits) next_state = EECC_ST_GAP;
        end
      end
      EECC_ST_GAP:
      begin
        // drop chip select one half period before checking ready
        next_cs = 1'b0;
        next_tcnt = 23'h0;
        if (tick)
        begin
          if (op == EECC_OP_WRITE || op == EECC_OP_WRITE_ALL_CMD || op == EECC_OP_ERASE ||
              op == EECC_OP_ERASE_ALL_CMD)
          begin
            next_cs = 1'b1;
            next_state = EECC_ST_WAIT;
          end
          else
          begin
            next_state = EECC_ST_DONE;
          end
        end
      end
      EECC_ST_WAIT:
      begin
        next_tcnt = tcnt + 23'h1;
        // the synchroniser still holds the idle pull level for a few cycles
        if (line_s && tcnt >= 23'(EECC_SYNC_LAT))
        begin
          next_cs = 1'b0;
          next_state = EECC_ST_DONE;
        end
        else if (tcnt == 23'(TMO_CYC - 1))
        begin
          next_cs = 1'b0;
          next_tmo = 1'b1;
          next_state = EECC_ST_IDLE;
          next_busy = 1'b0;
        end
      end
      EECC_ST_DONE:
      begin
        if (op == EECC_OP_READ) next_data = rsh;
        if (op == EECC_OP_RELOAD) next_loaded = rsh == EECC_SIGNATURE;
        next_busy = 1'b0;
        next_state = EECC_ST_IDLE;
      end
      default: next_state = EECC_ST_IDLE;
    endcase
  end

  // read mux and error answer, captured in the setup phase
  always_comb
  begin
    next_prdata = 32'h0;
    next_slverr = 1'b0;
    if (paddr == EECC_OFS_CMD)
    begin
      next_prdata[EECC_BIT_BUSY] = busy;
      next_prdata[EECC_POS_OP +: 3] = op;
      next_prdata[EECC_BIT_TMO] = tmo;
      next_prdata[EECC_BIT_LOADED] = loaded;
      next_prdata[7:0] = addr;
    end
    else if (paddr == EECC_OFS_DATA) next_prdata[7:0] = data;
    else next_slverr = 1'b1;
  end

  // ----------------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= EECC_ST_IDLE;
      op <= EECC_OP_READ;
      busy <= 1'b0;
      tmo <= 1'b0;
      loaded <= 1'b0;
      boot <= 1'b1;
      addr <= EECC_ADDR_RST;
      data <= EECC_DATA_RST;
      rsh <= 8'h00;
      tsh <= 19'h0;
      bitn <= 5'h00;
      div <= 8'h00;
      tcnt <= 23'h0;
      sk <= 1'b0;
      cs <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      state <= next_state;
      op <= next_op;
      busy <= next_busy;
      tmo <= next_tmo;
      loaded <= next_loaded;
      boot <= next_boot;
      addr <= next_addr;
      data <= next_data;
      rsh <= next_rsh;
      tsh <= next_tsh;
      bitn <= next_bitn;
      div <= next_div;
      tcnt <= next_tcnt;
      sk <= next_sk;
      cs <= next_cs;
      if (setup) prdata <= next_prdata;
      if (setup) pslverr <= next_slverr;
    end
  end

  // serial pins
  assign mem_cs = cs;
  assign mem_sk = sk;
  assign mem_di_out = tsh[18];
  assign serial_mem_data_line_out = tsh[18];
  assign serial_mem_data_line_oe = state == EECC_ST_SHIFT && bitn < 5'(EECC_FRAME_HDR);

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_timeout_sets_flag: assert property (ce && state == EECC_ST_WAIT && !line_s &&
    tcnt == 23'(TMO_CYC - 1) |=> tmo && !busy && state == EECC_ST_IDLE)
    else $error("time-out did not set flag");
  a_high_line_done: assert property (ce && state == EECC_ST_WAIT && line_s &&
    tcnt >= 23'(EECC_SYNC_LAT) |=> state == EECC_ST_DONE)
    else $error("high data line did not finish command");
  a_wait_only_erwr: assert property (state == EECC_ST_WAIT |-> op inside
    {EECC_OP_WRITE, EECC_OP_WRITE_ALL_CMD, EECC_OP_ERASE, EECC_OP_ERASE_ALL_CMD})
    else $error("non write command waited for ready");
  a_tmo_only_erwr: assert property ($rose(tmo) |-> op inside
    {EECC_OP_WRITE, EECC_OP_WRITE_ALL_CMD, EECC_OP_ERASE, EECC_OP_ERASE_ALL_CMD})
    else $error("time-out on a command that may not time out");
  a_loaded_by_reload: assert property ($rose(loaded) |-> $past(state) == EECC_ST_DONE &&
    op == EECC_OP_RELOAD && $past(rsh) == EECC_SIGNATURE)
    else $error("loaded flag set without valid reload");
  a_addr_in_frame: assert property (ce && start |=> tsh[15:8] ==
    ((op == EECC_OP_READ || op == EECC_OP_WRITE || op == EECC_OP_ERASE) ? addr : tsh[15:8]))
    else $error("frame does not carry location address");
  a_data_upper_zero: assert property ($past(setup) && paddr == EECC_OFS_DATA && !pslverr
    |-> prdata[31:8] == 24'h0)
    else $error("reserved data bits not zero");
  a_read_updates_data: assert property (ce && state == EECC_ST_DONE && op == EECC_OP_READ
    |=> data == $past(rsh))
    else $error("read byte not stored");
  a_erase_write_enable_cmd_pattern: assert property (ce && start && pwdata[EECC_POS_OP +: 3] == 3'(EECC_OP_ERASE_WRITE_ENABLE_CMD)
    |=> tsh[18:13] == 6'b100_11_0 || !ce)
    else $error("enable command pattern wrong");
  a_write_opcode: assert property (ce && start && pwdata[EECC_POS_OP +: 3] == 3'(EECC_OP_WRITE)
    |=> tsh[18:16] == 3'b101 && tsh[7:0] == data)
    else $error("write frame wrong");
  a_erase_opcode: assert property (ce && start && pwdata[EECC_POS_OP +: 3] == 3'(EECC_OP_ERASE)
    |=> tsh[18:16] == 3'b111)
    else $error("erase frame wrong");

  c_read_done: cover property (state == EECC_ST_DONE && op == EECC_OP_READ);
  c_write_ready: cover property (state == EECC_ST_WAIT ##1 state == EECC_ST_DONE);
  c_timeout: cover property ($rose(tmo));
  c_loaded: cover property ($rose(loaded));
endmodule
`default_nettype wire

// ===== tb/eecc_mem_model.sv
// behavioural serial eeprom that answers the command controller
`timescale 1ns/1ps
`default_nettype none
module eecc_mem_model
  import eecc_pkg::*;
(
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic present,
  input wire logic slow,
  output logic drv,
  output logic q
);
  logic [7:0] mem [256];
  logic [18:0] sr;
  logic [7:0] a;
  logic we = 1'b0;
  logic pend = 1'b0;
  logic prog = 1'b0;
  int nb;
  initial
  begin
    drv = 1'b0;
    q = 1'b0;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[0] = EECC_SIGNATURE;
  end
  // one frame, or one status phase after a program frame, per select
  always @(posedge cs)
  begin
    if (!present)
      pend = 1'b0;
    else if (pend)
    begin
      drv = 1'b1;
      q = 1'b0;
      #(prog ? (slow ? 400 : 40) : 5);
      q = 1'b1;  // ready
      @(negedge cs);
      drv = 1'b0;  // released: line shows its pull
      pend = 1'b0;
    end
    else
    begin
      nb = 0;
      while (cs)
      begin
        @(posedge sk or negedge cs);
        if (cs)
        begin
          sr = {sr[17:0], di};
          nb++;
          if (nb == 11 && sr[10:8] == 3'b110)
            read_out(sr[7:0]);
        end
      end
      if (nb == 19 || nb == 11)
        decode(nb == 11 ? {sr[10:0], 8'h00} : sr);
    end
  end
  // data bits change on the falling serial clock
  task automatic read_out(input logic [7:0] ra);
    for (int i = 7; i >= 0; i--)
    begin
      @(negedge sk);
      drv = 1'b1;
      q = mem[ra][i];
    end
    @(negedge cs);
    drv = 1'b0;
  endtask
  // program ops only take effect while enabled
  task automatic decode(input logic [18:0] h);
    logic [1:0] op;
    logic [1:0] sub;
    op = h[17:16];
    a = h[15:8];
    sub = a[7:6];
    pend = h[18] && op != 2'b10 && !(op == 2'b00 && sub[1] == sub[0]);
    prog = pend && we;
    if (h[18] && op == 2'b00 && sub[1] == sub[0])
      we = sub[0];
    if (prog && op == 2'b01)
      mem[a] = h[7:0];
    if (prog && op == 2'b11)
      mem[a] = 8'hff;
    if (prog && op == 2'b00)
      foreach (mem[i]) mem[i] = sub[0] ? h[7:0] : 8'hff;
  endtask
endmodule
`default_nettype wire

// ===== tb/eecc_tb_top.sv
// self-checking bench for the eeprom command controller
`timescale 1ns/1ps
`default_nettype none
module eecc_tb_top;
  import eecc_pkg::*;
  localparam int TMO = 200;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r, w;
  logic pready, pslverr, err, mem_cs, mem_sk, mem_di, d_out, d_oe, m_drv, m_q, line, b;
  logic pull = 1'b1;
  logic present = 1'b1;
  logic slow = 1'b0;
  logic ce = 1'b1;
  int lo;
  logic [7:0] sh [256];
  logic [7:0] a, d;
  time t0;
  int errors = 0;
  int n_checks = 0;
  always #2.5 pclk = ~pclk;
  // wire level from both drivers, else the pull
  assign line = d_oe ? d_out : (m_drv ? m_q : pull);
  eecc_top #(.TMO_CYC(TMO)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_cs(mem_cs), .mem_sk(mem_sk), .mem_di_out(mem_di),
    .serial_mem_data_line_in(line), .serial_mem_data_line_out(d_out),
    .serial_mem_data_line_oe(d_oe));
  eecc_mem_model mem_model (.cs(mem_cs), .sk(mem_sk), .di(mem_di), .present(present),
    .slow(slow), .drv(m_drv), .q(m_q));
  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    n_checks++;
    if (s !== e)
    begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
    end
  endtask
  task automatic apb(input logic wr_en, input logic [7:0] pa, input logic [31:0] pd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= pa;
    pwdata <= pd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poll busy with a bound
  task automatic poll();
    int n;
    n = 0;
    do
    begin
      apb(1'b0, EECC_OFS_CMD, 32'h0);
      n++;
    end
    while (r[EECC_BIT_BUSY] !== 1'b0 && n < 4000);
    chk(r[EECC_BIT_BUSY], 1'b0, "busy stuck");
  endtask
  task automatic run(input eecc_op_t op, input logic [7:0] ra);
    apb(1'b1, EECC_OFS_CMD, {1'b1, op, 20'h0, ra});
    poll();
  endtask
  task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
    apb(1'b1, EECC_OFS_DATA, {24'h0, wd});
    run(EECC_OP_WRITE, wa);
  endtask
  task automatic rd_chk(input logic [7:0] ra);
    run(EECC_OP_READ, ra);
    apb(1'b0, EECC_OFS_DATA, 32'h0);
    chk(r, {24'h0, sh[ra]}, "stored byte");
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    r = $urandom(61983);
    foreach (sh[i]) sh[i] = 8'h00;
    sh[0] = EECC_SIGNATURE;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, EECC_OFS_DATA, 32'h0);
    chk(r, 32'h0, "data reset");
    poll();
    chk(r[9:0], {2'b01, EECC_ADDR_RST}, "load and address");
    apb(1'b0, 8'h40, 32'h0);
    chk(err, 1'b1, "unmapped");
    w = $urandom;
    apb(1'b1, EECC_OFS_DATA, w);
    apb(1'b0, EECC_OFS_DATA, 32'h0);
    chk(r, {24'h0, w[7:0]}, "data field");
    $display("done: registers");
    wr(8'h21, 8'h3c);
    run(EECC_OP_ERASE, 8'h00);
    rd_chk(8'h21);
    rd_chk(8'h00);
    run(EECC_OP_ERASE_WRITE_ENABLE_CMD, 8'hc0);
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 8'hff : 8'($urandom);
      d = 8'($urandom);
      slow = 1'($urandom);
      wr(a, d);
      sh[a] = d;
      rd_chk(a);
    end
    // clock enable held low right after the read frame starts must not disturb the read
    apb(1'b1, EECC_OFS_CMD, {1'b1, EECC_OP_READ, 20'h0, a});
    ce <= 1'b0;
    repeat (50 + 8'($urandom)) @(posedge pclk);
    ce <= 1'b1;
    poll();
    apb(1'b0, EECC_OFS_DATA, 32'h0);
    chk(r, {24'h0, sh[a]}, "frozen read");
    a = 8'($urandom);
    run(EECC_OP_ERASE, a);
    sh[a] = 8'hff;
    rd_chk(a);
    rd_chk(a + 8'h01);
    d = 8'($urandom);
    apb(1'b1, EECC_OFS_DATA, {24'h0, d});
    run(EECC_OP_WRITE_ALL_CMD, 8'h40);
    foreach (sh[i]) sh[i] = d;
    rd_chk(8'($urandom));
    run(EECC_OP_ERASE_ALL_CMD, 8'h80);
    foreach (sh[i]) sh[i] = 8'hff;
    rd_chk(8'($urandom));
    run(EECC_OP_RELOAD, 8'h00);
    chk(r[8], 1'b0, "bad signature");
    wr(8'h00, EECC_SIGNATURE);
    run(EECC_OP_RELOAD, 8'h00);
    chk(r[8], 1'b1, "good signature");
    run(EECC_OP_EWDS, 8'h00);
    wr(8'h05, 8'h11);
    rd_chk(8'h05);
    $display("done: memory ops");
    present = 1'b0;
    wr(8'h05, 8'h11);
    chk(r[9], 1'b0, "pulled high");
    pull <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      t0 = $time;
      run(eecc_op_t'(i), 8'hc0);
      b = i inside {[3:6]};
      chk(r[9], b, "time-out flag");
      // frame, chip select gap, then the full time-out count
      lo = (2 * ((i < 5) ? EECC_FRAME_DATA : EECC_FRAME_HDR) + 1) * EECC_SK_HALF_CYC + TMO;
      if (b)
        chk(($time - t0) / 5 inside {[lo : lo + 12]}, 1'b1, "time-out span");
    end
    $display("done: missing memory");
    summarize();
  end
  // watchdog against a hang
  initial
  begin
    #400000;
    errors++;
    summarize();
  end
endmodule
`default_nettype wire
